/* File: src/bcd_real_pkg.sv */
// Package for the accumulator arithmetic unit: operations, operand modes,
// flag and command carriers, encoding constants and state names.
// Assumes a word memory of 16-bit words reached by a one-word read port.
package bcd_real_pkg;

  // ==========================================================================
  // Operations, operand modes and states
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_SUM_BCD_WORD,
    sum_bcd_double,
    OP_SUM_REAL,
    OP_DIFF_BCD_WORD,
    diff_bcd_double
  } op_e;

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_POINTER,
    MODE_CONST
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PTR_REQ,
    ST_PTR_WAIT,
    ST_LO_REQ,
    ST_LO_WAIT,
    ST_HI_REQ,
    ST_HI_WAIT,
    ST_EXEC
  } state_e;

  // ==========================================================================
  // Widths, field positions and constants
  // ==========================================================================
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int ACC_W = 32;
  localparam int BCD_DIGITS = 8;
  localparam int WORD_DIGITS = 4;
  localparam int CARRY32_BIT = 33;
  localparam int CARRY16_BIT = 32;
  localparam int SIGN_BIT = 31;
  localparam int EXP_HI = 30;
  localparam int EXP_LO = 23;
  localparam logic [7:0] EXP_MAX = 8'hff;
  localparam logic [31:0] REAL_QNAN = 32'h7fc00000;
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [4:0] BCD_BASE = 5'h0a;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    op_e op;
    mode_e mode;
    logic [ADDR_W-1:0] addr;
    logic [ACC_W-1:0] konst;
  } cmd_s;

  typedef struct packed {
    logic result_zero_flag;
    logic word_borrow_flag;
    logic double_borrow_flag;
    logic word_carry_flag;
    logic double_carry_flag;
    logic negative_flag;
    logic bad_pointer_flag;
    logic invalid_float_flag;
    logic sign_error_flag;
    logic underflow_flag;
    logic invalid_digit_flag;
  } flags_s;

  localparam flags_s FLAGS_RESET = '0;

  typedef struct packed {
    logic [31:0] res;
    logic ovf;
    logic unf;
    logic inv;
  } fres_s;

endpackage

/* File: src/bcd_real_add_sub_unit.sv */
// Accumulator arithmetic unit: BCD sum and difference in word and double
// width, and single-precision real sum, with discrete status flags.
// Assumes one sequencer issuing one command at a time and a word memory
// that answers each read with one mem_rvalid pulse, any number of cycles later.
`timescale 1ns/1ps

// How it works
// - Word BCD sum adds a memory word to accumulator low 16 bits.
// - Word BCD sum refuses a constant operand; memory or pointer only.
// - Double BCD sum adds a two-word or constant 8-digit operand to accumulator.
// - Zero flag follows whether the written accumulator equals zero.
// - Word carry flag set on carry out of the fourth BCD digit.
// - Double carry flag set on carry out of the eighth BCD digit.
// - Negative flag set when the written accumulator value is negative and is not an invalid real result.
// - Invalid digit flag set when a BCD operand has a nibble above nine.
// - Real sum adds a constant or two-word real to the accumulator.
// - Bad pointer flag set when a pointer addresses outside word memory.
// - Invalid float flag set when the real result is not a valid number.
// - Sign error flag set when the real sum overflows its range.
// - Underflow flag set when a real sum underflows.
// - Word BCD difference subtracts a memory word from accumulator low bits.
// - Double BCD difference subtracts a two-word or constant operand.
// - Word borrow flag set on borrow beyond the fourth BCD digit.
// - Double borrow flag set on borrow beyond the eighth BCD digit.
// - Each operation rewrites its own flags, both flags of its carry or borrow pair and the invalid digit flag, or on an invalid digit that flag
// alone outside pointer mode; a pointer-mode operation that executes also clears the bad pointer flag; others hold.
module bcd_real_add_sub_unit
  import bcd_real_pkg::*;
#(
  parameter int MEM_WORDS = 4096
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command from the sequencer
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  // Direct accumulator load from the sequencer
  input wire logic acc_load,
  input wire logic [ACC_W-1:0] acc_load_data,
  // Word memory read port
  output logic mem_rd,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [WORD_W-1:0] mem_rdata,
  // Results and status
  output logic busy,
  output logic done,
  output logic refused,
  output logic [ACC_W-1:0] acc,
  output flags_s flags
);

  typedef struct packed {
    state_e st;
    cmd_s cmd;
    logic [ADDR_W-1:0] eff;
    logic [ACC_W-1:0] opnd;
    logic [ACC_W-1:0] acc;
    flags_s flags;
    logic mem_rd;
    logic busy;
    logic done;
    logic refused;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ==========================================================================
  // Arithmetic helpers
  // ==========================================================================
  function automatic logic is_double(input op_e op);
    return (op == sum_bcd_double) || (op == diff_bcd_double) || (op == OP_SUM_REAL);
  endfunction

  function automatic logic bcd_ok(input logic [ACC_W-1:0] x);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < BCD_DIGITS; i++)
      if (x[4*i +: 4] > BCD_MAX_DIGIT)
        ok = 1'b0;
    return ok;
  endfunction

  // Returns {carry out of digit 8, carry out of digit 4, result}.
  function automatic logic [CARRY32_BIT:0] bcd_arith(input logic [ACC_W-1:0] a,
                                                      input logic [ACC_W-1:0] b,
                                                      input logic sub);
    logic [4:0] t;
    logic c;
    logic c16;
    logic [ACC_W-1:0] r;
    c = 1'b0;
    c16 = 1'b0;
    r = '0;
    t = '0;
    for (int i = 0; i < BCD_DIGITS; i++)
    begin
      if (sub)
      begin
        t = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, c};
        c = t[4];
        if (c)
          t = t + BCD_BASE;
      end
      else
      begin
        t = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
        c = (t >= BCD_BASE);
        if (c)
          t = t - BCD_BASE;
      end
      r[4*i +: 4] = t[3:0];
      if (i == WORD_DIGITS - 1)
        c16 = c;
    end
    return {c, c16, r};
  endfunction

  // Single-precision sum. Subnormals flush to zero and the result is truncated;
  // the saving in area was judged worth more than round-to-nearest here.
  function automatic fres_s real_add(input logic [31:0] a, input logic [31:0] b);
    fres_s f;
    logic [31:0] x;
    logic [31:0] y;
    logic [26:0] mx;
    logic [26:0] my;
    logic [27:0] sm;
    logic [26:0] nm;
    logic [7:0] d;
    logic [4:0] lz;
    logic signed [9:0] e;
    f = '0;
    lz = '0;
    nm = '0;
    e = '0;
    if (a[EXP_HI:EXP_LO] == EXP_MAX || b[EXP_HI:EXP_LO] == EXP_MAX)
    begin
      f.res = REAL_QNAN;
      f.inv = 1'b1;
      return f;
    end
    if (a[EXP_HI:0] >= b[EXP_HI:0])
    begin
      x = a;
      y = b;
    end
    else
    begin
      x = b;
      y = a;
    end
    mx = (x[EXP_HI:EXP_LO] == 8'h00) ? '0 : {1'b1, x[22:0], 3'b000};
    my = (y[EXP_HI:EXP_LO] == 8'h00) ? '0 : {1'b1, y[22:0], 3'b000};
    d = x[EXP_HI:EXP_LO] - y[EXP_HI:EXP_LO];
    my = (d > 8'h1a) ? '0 : (my >> d);
    sm = (x[SIGN_BIT] == y[SIGN_BIT]) ? {1'b0, mx} + {1'b0, my} : {1'b0, mx} - {1'b0, my};
    if (sm == '0)
      return f;
    if (sm[27])
    begin
      nm = sm[27:1];
      e = 10'(x[EXP_HI:EXP_LO]) + 10'sd1;
    end
    else
    begin
      for (int i = 0; i < 27; i++)
        if (sm[i])
          lz = 5'(26 - i);
      nm = sm[26:0] << lz;
      e = 10'(x[EXP_HI:EXP_LO]) - 10'(lz);
    end
    if (e >= 10'sd255)
    begin
      f.res = {x[SIGN_BIT], EXP_MAX, 23'h0};
      f.ovf = 1'b1;
      f.inv = 1'b1;
    end
    else if (e <= 10'sd0)
      f.unf = 1'b1;
    else
      f.res = {x[SIGN_BIT], e[7:0], nm[25:3]};
    return f;
  endfunction

  // ==========================================================================
  // Sequencing and datapath
  // ==========================================================================
  logic [CARRY32_BIT:0] bcd_r;
  fres_s fr;
  logic [ACC_W-1:0] a_in;
  logic [ACC_W-1:0] b_in;
  logic sub_op;
  logic dbl_op;

  always_comb
  begin
    dbl_op = is_double(s_q.cmd.op);
    sub_op = (s_q.cmd.op == OP_DIFF_BCD_WORD) || (s_q.cmd.op == diff_bcd_double);
    a_in = dbl_op ? s_q.acc : {16'h0000, s_q.acc[15:0]};
    b_in = dbl_op ? s_q.opnd : {16'h0000, s_q.opnd[15:0]};
    bcd_r = bcd_arith(a_in, b_in, sub_op);
    fr = real_add(s_q.acc, s_q.opnd);
  end

  always_comb
  begin
    s_d = s_q;
    s_d.mem_rd = 1'b0;
    s_d.done = 1'b0;
    s_d.refused = 1'b0;
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (acc_load)
        begin
          s_d.acc = acc_load_data;
        end
        if (cmd_valid)
        begin
          s_d.cmd = cmd;
          s_d.eff = cmd.addr;
          if (cmd.mode == MODE_CONST && !is_double(cmd.op))
          begin
            s_d.refused = 1'b1;
            s_d.done = 1'b1;
          end
          else if (cmd.mode == MODE_CONST)
          begin
            s_d.opnd = cmd.konst;
            s_d.busy = 1'b1;
            s_d.st = ST_EXEC;
          end
          else
          begin
            s_d.busy = 1'b1;
            s_d.st = (cmd.mode == MODE_POINTER) ? ST_PTR_REQ : ST_LO_REQ;
          end
        end
      end
      ST_PTR_REQ:
      begin
        s_d.mem_rd = 1'b1;
        s_d.st = ST_PTR_WAIT;
      end
      ST_PTR_WAIT:
      begin
        if (mem_rvalid)
        begin
          // A double operand needs its second word inside memory as well.
          if (32'(mem_rdata) + (is_double(s_q.cmd.op) ? 32'd1 : 32'd0) >= 32'(MEM_WORDS))
          begin
            s_d.flags.bad_pointer_flag = 1'b1;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
          else
          begin
            s_d.eff = mem_rdata;
            s_d.st = ST_LO_REQ;
          end
        end
      end
      ST_LO_REQ:
      begin
        s_d.mem_rd = 1'b1;
        s_d.st = ST_LO_WAIT;
      end
      ST_LO_WAIT:
      begin
        if (mem_rvalid)
        begin
          s_d.opnd = {16'h0000, mem_rdata};
          s_d.eff = s_q.eff + 16'h0001;
          s_d.st = dbl_op ? ST_HI_REQ : ST_EXEC;
        end
      end
      ST_HI_REQ:
      begin
        s_d.mem_rd = 1'b1;
        s_d.st = ST_HI_WAIT;
      end
      ST_HI_WAIT:
      begin
        if (mem_rvalid)
        begin
          s_d.opnd = {mem_rdata, s_q.opnd[15:0]};
          s_d.st = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        // Cleared here rather than at the pointer read so all flags move with done.
        s_d.flags.bad_pointer_flag &= (s_q.cmd.mode != MODE_POINTER);
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
        if (s_q.cmd.op == OP_SUM_REAL)
        begin
          s_d.acc = fr.res;
          s_d.flags.result_zero_flag = (fr.res[EXP_HI:0] == '0);
          s_d.flags.negative_flag = fr.res[SIGN_BIT] && !fr.inv;
          s_d.flags.invalid_float_flag = fr.inv;
          s_d.flags.sign_error_flag = fr.ovf;
          s_d.flags.underflow_flag = fr.unf;
          s_d.flags.invalid_digit_flag = 1'b0;
        end
        else if (!bcd_ok(a_in) || !bcd_ok(b_in))
        begin
          // Accumulator is left as it was so bad data does not propagate.
          s_d.flags.invalid_digit_flag = 1'b1;
        end
        else
        begin
          // Word results clear the upper half; the zero test covers all 32 bits.
          s_d.acc = dbl_op ? bcd_r[ACC_W-1:0] : {16'h0000, bcd_r[15:0]};
          s_d.flags.invalid_digit_flag = 1'b0;
          s_d.flags.result_zero_flag = (s_d.acc == '0);
          if (sub_op)
          begin
            s_d.flags.word_borrow_flag = !dbl_op && bcd_r[CARRY16_BIT];
            s_d.flags.double_borrow_flag = dbl_op && bcd_r[CARRY32_BIT];
            s_d.flags.negative_flag = dbl_op ? bcd_r[CARRY32_BIT] : bcd_r[CARRY16_BIT];
          end
          else
          begin
            s_d.flags.word_carry_flag = !dbl_op && bcd_r[CARRY16_BIT];
            s_d.flags.double_carry_flag = dbl_op && bcd_r[CARRY32_BIT];
            s_d.flags.negative_flag = 1'b0;
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{st: ST_IDLE, cmd: '0, eff: '0, opnd: '0, acc: ACC_RESET,
               flags: FLAGS_RESET, mem_rd: 1'b0, busy: 1'b0, done: 1'b0,
               refused: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign mem_rd = s_q.mem_rd;
  assign mem_addr = s_q.eff;
  assign busy = s_q.busy;
  assign done = s_q.done;
  assign refused = s_q.refused;
  assign acc = s_q.acc;
  assign flags = s_q.flags;

endmodule

/* File: dv/bcd_real_add_sub_unit_props.sv */
// Checker for the accumulator arithmetic unit, bound to its top module.
// Assumes the sequencer only pulses cmd_valid while busy is low.
`timescale 1ns/1ps

module bcd_real_add_sub_unit_props
  import bcd_real_pkg::*;
#(
  parameter int MEM_WORDS = 4096
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command side
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  input wire logic acc_load,
  input wire logic [ACC_W-1:0] acc_load_data,
  // Memory side
  input wire logic mem_rd,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [WORD_W-1:0] mem_rdata,
  // Results
  input wire logic busy,
  input wire logic done,
  input wire logic refused,
  input wire logic [ACC_W-1:0] acc,
  input wire flags_s flags
);
  // ==========================================
  // Assertions
  // ==========================================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic take;
  logic wide;
  assign take = cmd_valid && !busy;
  assign wide = cmd.op == sum_bcd_double || cmd.op == diff_bcd_double || cmd.op == OP_SUM_REAL;

  // A refused command taken in the cycle of an earlier done gives a second done.
  a_done_pulse: assert property (done |=> !done || $past(take))
    else $error("done held too long");
  a_refuse_const: assert property (take && cmd.mode == MODE_CONST && !wide
    |=> done && refused && !busy) else $error("word op with constant not refused");
  a_const_timing: assert property (take && cmd.mode == MODE_CONST && wide
    |=> busy && !done ##1 done && !busy) else $error("constant op timing wrong");
  a_first_read: assert property (take && cmd.mode != MODE_CONST
    |=> ##1 mem_rd && mem_addr == $past(cmd.addr, 2)) else $error("first read address wrong");
  a_zero_follows: assert property (done && !refused && !flags.invalid_digit_flag
    && !flags.bad_pointer_flag |-> flags.result_zero_flag == (acc == '0))
    else $error("zero flag disagrees with acc");
  a_carry_excl: assert property (
    !(flags.word_carry_flag && flags.double_carry_flag)) else $error("both carry flags set");
  a_borrow_excl: assert property (
    !(flags.word_borrow_flag && flags.double_borrow_flag)) else $error("both borrow flags set");
  a_flags_hold: assert property ($changed(flags) |-> done)
    else $error("flags changed outside done");
  a_rd_pulse: assert property (mem_rd |=> !mem_rd) else $error("mem_rd longer than a cycle");
  a_busy_ends: assert property ($rose(busy) |-> ##[1:60] !busy) else $error("busy hung");

  c_refused: cover property (done && refused);
  c_bad_ptr: cover property (done && flags.bad_pointer_flag);
  c_ovf: cover property (done && flags.sign_error_flag);
endmodule

bind bcd_real_add_sub_unit bcd_real_add_sub_unit_props #(.MEM_WORDS(MEM_WORDS)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
  .acc_load(acc_load), .acc_load_data(acc_load_data), .mem_rd(mem_rd),
  .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
  .busy(busy), .done(done), .refused(refused), .acc(acc), .flags(flags));

/* File: dv/word_mem_model.sv */
// Word memory model answering each read after lat cycles.
// Assumes the bench fills m and sets lat between commands.
`timescale 1ns/1ps

module word_mem_model
  import bcd_real_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Read port
  input wire logic mem_rd,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic mem_rvalid,
  output logic [WORD_W-1:0] mem_rdata
);
  // ==========================================
  // Storage and latency
  // ==========================================
  logic [WORD_W-1:0] m [0:4095];
  int lat = 2;
  int cnt;
  logic [11:0] a;

  // Data toggles when not valid so a design sampling late sees garbage.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h5a5a;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd)
      begin
        cnt <= lat;
        a <= mem_addr[11:0];
      end
      else if (cnt != 0)
        cnt <= cnt - 1;
      if (cnt == 1)
      begin
        mem_rvalid <= 1'b1;
        mem_rdata <= m[a];
      end
    end
  end
endmodule

/* File: dv/bcd_real_add_sub_unit_bench.sv */
// Self-checking bench for the accumulator arithmetic unit.
// Assumes the word memory model and the bound checker are compiled with it.
`timescale 1ns/1ps

module bcd_real_add_sub_unit_bench;
  import bcd_real_pkg::*;
  logic clk_sys;
  logic rst_n;
  logic cmd_valid;
  cmd_s cmd;
  logic acc_load;
  logic [ACC_W-1:0] acc_load_data;
  logic mem_rd;
  logic [ADDR_W-1:0] mem_addr;
  logic mem_rvalid;
  logic [WORD_W-1:0] mem_rdata;
  logic busy;
  logic done;
  logic refused;
  logic [ACC_W-1:0] acc;
  flags_s flags;
  logic rf;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  bcd_real_add_sub_unit DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .acc_load(acc_load), .acc_load_data(acc_load_data), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .busy(busy),
    .done(done), .refused(refused), .acc(acc), .flags(flags));
  word_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  // ==========================================
  // Helpers
  // ==========================================
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ld(input logic [31:0] v);
    @(posedge clk_sys);
    acc_load <= 1'b1;
    acc_load_data <= v;
    @(posedge clk_sys);
    acc_load <= 1'b0;
  endtask

  task automatic op(input op_e o, input mode_e md, input logic [15:0] a, input logic [31:0] k);
    int i;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{op: o, mode: md, addr: a, konst: k};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (i = 0; i < 60; i++)
    begin
      @(negedge clk_sys);
      if (done === 1'b1)
        break;
    end
    rf = refused;
    chk(done, 1);
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_word;
    mem.m[10] = 16'h1234;
    mem.m[11] = 16'h0001;
    mem.m[12] = 16'h0002;
    ld(32'h12345678);
    op(OP_SUM_BCD_WORD, MODE_DIRECT, 16'h000a, 0);
    chk(acc, 32'h00006912);
    ld(32'h00009999);
    op(OP_SUM_BCD_WORD, MODE_DIRECT, 16'h000b, 0);
    chk(flags.result_zero_flag, 1);
    chk(flags.word_carry_flag, 1);
    ld(32'h00000001);
    op(OP_DIFF_BCD_WORD, MODE_DIRECT, 16'h000c, 0);
    chk(acc, 32'h00009999);
    chk(flags.word_borrow_flag, 1);
    chk(flags.negative_flag, 1);
    chk(flags.word_carry_flag, 1);
  endtask

  task automatic t_double;
    mem.m[20] = 16'h5678;
    mem.m[21] = 16'h1234;
    ld(32'h99999999);
    op(sum_bcd_double, MODE_CONST, 0, 32'h00000001);
    chk(acc, 32'h00000000);
    chk(flags.double_carry_flag, 1);
    ld(32'h00000001);
    op(sum_bcd_double, MODE_DIRECT, 16'h0014, 0);
    chk(acc, 32'h12345679);
    ld(32'h00000000);
    op(diff_bcd_double, MODE_CONST, 0, 32'h00000001);
    chk(acc, 32'h99999999);
    chk(flags.double_borrow_flag, 1);
  endtask

  task automatic t_faults;
    mem.m[30] = 16'h0040;
    mem.m[31] = 16'hffff;
    mem.m[64] = 16'h0005;
    ld(32'h00000005);
    op(OP_SUM_BCD_WORD, MODE_CONST, 0, 32'h00000001);
    chk(rf, 1);
    chk(acc, 32'h00000005);
    ld(32'h00000003);
    op(OP_SUM_BCD_WORD, MODE_POINTER, 16'h001e, 0);
    chk(acc, 32'h00000008);
    chk(flags.bad_pointer_flag, 0);
    op(OP_SUM_BCD_WORD, MODE_POINTER, 16'h001f, 0);
    chk(flags.bad_pointer_flag, 1);
    chk(acc, 32'h00000008);
    op(OP_SUM_BCD_WORD, MODE_POINTER, 16'h001e, 0);
    chk(flags.bad_pointer_flag, 0);
    chk(acc, 32'h00000013);
    ld(32'h0000001a);
    op(sum_bcd_double, MODE_CONST, 0, 32'h00000001);
    chk(flags.invalid_digit_flag, 1);
    chk(acc, 32'h0000001a);
  endtask

  task automatic t_real;
    mem.m[50] = 16'h0000;
    mem.m[51] = 16'h3f80;
    ld(32'h3f800000);
    op(OP_SUM_REAL, MODE_DIRECT, 16'h0032, 0);
    chk(acc, 32'h40000000);
    ld(32'h7f7fffff);
    op(OP_SUM_REAL, MODE_CONST, 0, 32'h7f7fffff);
    chk(flags.sign_error_flag, 1);
    ld(32'h7fc00000);
    op(OP_SUM_REAL, MODE_CONST, 0, 32'h3f800000);
    chk(flags.invalid_float_flag, 1);
    ld(32'h00800001);
    op(OP_SUM_REAL, MODE_CONST, 0, 32'h80800000);
    chk(flags.underflow_flag, 1);
    chk(acc, 32'h00000000);
  endtask

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    acc_load = 1'b0;
    acc_load_data = '0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    mem.lat = 1;
    t_word();
    t_double();
    mem.lat = 5;
    t_faults();
    t_real();
    end_of_test();
  end
endmodule
